// *** pkg/dis_pkg.sv ***
// Constants for the drive input and setpoint selection logic.
// Assumes frequencies in 0.01 Hz units and times in 0.1 s units.
package dis_pkg;
    // Terminal function codes.
    localparam logic [5:0] FN_NONE = 6'h00;
    localparam logic [5:0] FN_RUN_FWD = 6'h01;
    localparam logic [5:0] FN_RUN_BWD = 6'h02;
    localparam logic [5:0] FN_RESET = 6'h06;
    localparam logic [5:0] FN_SRC_SW = 6'h07;
    localparam logic [5:0] FN_INCH_FWD = 6'h08;
    localparam logic [5:0] FN_INCH_BWD = 6'h09;
    localparam logic [5:0] FN_UP = 6'h0a;
    localparam logic [5:0] FN_DOWN = 6'h0b;
    localparam logic [5:0] FN_UPDN_CLR = 6'h0c;
    localparam logic [5:0] FN_COAST = 6'h0d;
    localparam logic [5:0] FN_FSTOP = 6'h0e;
    localparam logic [5:0] FN_DCBRAKE = 6'h0f;
    localparam logic [5:0] FN_HOLD = 6'h10;
    localparam logic [5:0] FN_INHIBIT = 6'h11;
    localparam logic [5:0] FN_STEP1 = 6'h12;
    localparam logic [5:0] FN_SSBIT0 = 6'h1a;
    localparam logic [5:0] FN_RAMP1 = 6'h1e;
    localparam logic [5:0] FN_RTBIT0 = 6'h22;
    localparam logic [5:0] FN_RTBIT1 = 6'h23;
    localparam logic [5:0] FN_FSTOP_NC = 6'h24;
    localparam logic [5:0] FN_EXTF_NO = 6'h25;
    localparam logic [5:0] FN_EXTF_NC = 6'h26;
    localparam logic [5:0] FN_EXTI_NO = 6'h27;
    localparam logic [5:0] FN_EXTI_NC = 6'h28;
    localparam logic [5:0] FN_SEQ_FIRST = 6'h2a;
    localparam logic [5:0] FN_PID_START = 6'h2f;
    localparam logic [5:0] FN_PULSE = 6'h36;
    localparam logic [5:0] FN_MAX_LOW = 6'h35;
    localparam logic [5:0] FN_MAX_HIGH = 6'h39;
    // Combination select range and PID source code.
    localparam logic [2:0] COMB_PID_LO = 3'h3;
    localparam logic [2:0] COMB_PID_HI = 3'h5;
    localparam logic [3:0] SRC_PID = 4'h9;
    // Fan temperature thresholds in degrees C.
    localparam logic [7:0] FAN_ON_TEMP = 8'h3c;
    localparam logic [7:0] FAN_OFF_TEMP = 8'h32;
    // Ramp time limits in 0.1 s.
    localparam logic [15:0] RAMP_MIN = 16'h0001;
    localparam logic [15:0] RAMP_MAX = 16'h8ca0;
    // Step frequency defaults in 0.01 Hz: 5,10,15,20,30,40,50 Hz.
    localparam logic [15:0] STEP_DEF [7] = '{16'h01f4, 16'h03e8,
        16'h05dc, 16'h07d0, 16'h0bb8, 16'h0fa0, 16'h1388};
endpackage : dis_pkg

// *** logic/dis_term_cond.sv ***
// Terminal conditioner: two-stage synchroniser and polarity for one input.
// Assumes the terminal level is asynchronous to clk.
`timescale 1ns/1ps
module dis_term_cond (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Raw level and polarity.
    input wire logic raw_pin,
    input wire logic open_valid,
    // Conditioned level.
    output logic asserted
);
    logic sync1; // First stage, read only by the second.
    logic sync2; // Settled level.

    // Two flops remove metastability before anything decodes.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= raw_pin;
            sync2 <= sync1;
        end
    end

    // Raw high means shorted to common; open-valid flips the sense.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            asserted <= 1'b0;
        end else begin
            asserted <= sync2 ^ open_valid;
        end
    end
endmodule : dis_term_cond

// *** logic/dis_input_setpoint.sv ***
// Drive input terminals, function decode and setpoint selection.
// Assumes settings are held stable by the parameter store; raw pins are
// high when shorted to common.
// Notes on behaviour
// - All skip centres zero disables skipping
// - Three skip bands, union forms wider band
// - Seven preset step frequencies, clamped, defaults
// - Combination 3-5 with PID uses step one
// - Ramp sets two to four, 0.1-3600 s
// - No ramp terminal active selects set one
// - Sequencer or inch ignores ramp terminals
// - Auto fan runs while drive runs
// - Stopped auto fan: on above 60, off below 50
// - Fan mode one always on
// - Phase order setting swaps output sequence
// - Reverse inhibit: keypad reverse gives zero speed
// - Reverse inhibit blocks reverse inch and run
// - Polarity: close valid or open valid
// - Eight function codes, ranges 53 and 57
// - Small models: four takes terminal eight's code, five reads bits past the last code
// - Shared code active if any terminal asserted
// - Decode codes 1, 2 and 6 through 17
// - Decode step, ramp, stop, fault, interrupt codes
// - Decode sequencer, counter, pulse inputs
// - Code zero terminal is ignored entirely
// - Reset acts only on rising edge
// - Reset clears fault, stops running drive
// - Ramp bits high,low select sets one to four
`timescale 1ns/1ps
module dis_input_setpoint #(
    parameter int N_TERM = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Terminals.
    input wire logic [N_TERM-1:0] multi_function_input_pins,
    input wire logic terminal_polarity_setting,
    input wire logic [6*N_TERM-1:0] terminal_function_codes,
    input wire logic small_model,
    // Frequency settings in 0.01 Hz.
    input wire logic [15:0] max_freq,
    input wire logic [15:0] base_freq,
    input wire logic [47:0] skip_band_settings,
    input wire logic [15:0] skip_bandwidth,
    input wire logic [16*7-1:0] preset_step_frequencies,
    input wire logic preset_load,
    input wire logic [2:0] freq_combination_select,
    input wire logic [3:0] primary_freq_source,
    // Ramp settings in 0.1 s.
    input wire logic [31:0] ramp_time_set_1,
    input wire logic [16*6-1:0] ramp_time_sets_2_to_4,
    input wire logic [31:0] mode_ramp_times,
    input wire logic seq_or_inch_active,
    // Fan, phase and direction.
    input wire logic fan_policy_setting,
    input wire logic [7:0] stage_temp,
    input wire logic phase_order_setting,
    input wire logic reverse_inhibit_setting,
    input wire logic keypad_reverse,
    input wire logic running,
    input wire logic faulted,
    // Setpoint outputs.
    output logic [15:0] target_freq,
    output logic [15:0] pid_amplitude,
    output logic [15:0] accel_time,
    output logic [15:0] decel_time,
    output logic fan_on,
    output logic phase_swap,
    output logic zero_speed,
    // Decoded functions.
    output logic [N_TERM-1:0] term_asserted,
    output logic [63:0] func_active,
    output logic start_fwd,
    output logic start_bwd,
    output logic fault_clear,
    output logic stop_request
);
    initial begin
        if (N_TERM != 8) $error("dis_input_setpoint needs eight terminals");
    end

    // Clamp a frequency to the maximum.
    function automatic logic [15:0] clamp_f(input logic [15:0] f,
                                            input logic [15:0] m);
        clamp_f = (f > m) ? m : f;
    endfunction : clamp_f

    // Effective code with range check; out of range acts as none.
    function automatic logic [5:0] eff_code(input logic [5:0] c,
                                            input logic [5:0] lim);
        eff_code = (c > lim) ? dis_pkg::FN_NONE : c;
    endfunction : eff_code

    // Conditioned terminal levels.
    for (genvar g = 0; g < N_TERM; g++) begin : g_term
        dis_term_cond u_cond (
            .clk(clk),
            .nrst(nrst),
            .raw_pin(multi_function_input_pins[g]),
            .open_valid(terminal_polarity_setting),
            .asserted(term_asserted[g])
        );
    end

    // Per-terminal effective code; small models freeze six to eight.
    logic [5:0] code [N_TERM];
    always_comb begin
        for (int i = 0; i < N_TERM; i++) begin
            code[i] = eff_code(terminal_function_codes[6*i +: 6],
                               (i >= 6) ? dis_pkg::FN_MAX_HIGH
                                        : dis_pkg::FN_MAX_LOW);
        end
        if (small_model) begin
            code[3] = eff_code(terminal_function_codes[42 +: 6],
                               dis_pkg::FN_MAX_HIGH);
            code[4] = eff_code(terminal_function_codes[48 +: 6],
                               dis_pkg::FN_MAX_HIGH);
            code[5] = dis_pkg::FN_NONE;
            code[6] = dis_pkg::FN_NONE;
            code[7] = dis_pkg::FN_NONE;
        end
    end

    // OR of terminals per function; code zero contributes nothing.
    logic [63:0] next_func;
    always_comb begin
        next_func = '0;
        for (int i = 0; i < N_TERM; i++) begin
            if (code[i] != dis_pkg::FN_NONE) begin
                next_func[code[i]] = next_func[code[i]] |
                                     term_asserted[i];
            end
        end
        // Pulse and speed inputs are only legal on the last two pins.
        for (int i = 0; i < 6; i++) begin
            if (code[i] >= dis_pkg::FN_PULSE && !small_model) begin
                next_func[code[i]] = 1'b0;
            end
        end
        next_func[41] = 1'b0;
        next_func[48] = 1'b0;
        next_func[53] = 1'b0;
    end

    // Registered function vector.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            func_active <= '0;
        end else begin
            func_active <= next_func;
        end
    end

    // Reset function edge detect; previous level held here.
    logic reset_prev;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reset_prev <= 1'b0;
        end else begin
            reset_prev <= func_active[dis_pkg::FN_RESET];
        end
    end
    logic reset_edge;
    assign reset_edge = func_active[dis_pkg::FN_RESET] & ~reset_prev;

    // Reset pulses: clears fault, or stops a running drive.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fault_clear <= 1'b0;
        end else begin
            fault_clear <= reset_edge & faulted;
        end
    end

    // Stop from reset edge, forced stop, coast, inhibit, or external fault.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stop_request <= 1'b0;
        end else begin
            stop_request <= (reset_edge & running)
                | func_active[dis_pkg::FN_FSTOP]
                | func_active[dis_pkg::FN_COAST]
                | func_active[dis_pkg::FN_INHIBIT]
                | func_active[dis_pkg::FN_EXTF_NO];
        end
    end

    // Start commands; reverse ones are blocked when inhibited.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            start_fwd <= 1'b0;
            start_bwd <= 1'b0;
        end else begin
            start_fwd <= func_active[dis_pkg::FN_RUN_FWD]
                       | func_active[dis_pkg::FN_INCH_FWD];
            start_bwd <= (func_active[dis_pkg::FN_RUN_BWD]
                        | func_active[dis_pkg::FN_INCH_BWD])
                       & ~reverse_inhibit_setting;
        end
    end

    // Preset store; loaded defaults at reset, clamped on load.
    logic [15:0] preset [7];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 7; i++) preset[i] <= dis_pkg::STEP_DEF[i];
        end else if (preset_load) begin
            for (int i = 0; i < 7; i++) begin
                preset[i] <= clamp_f(preset_step_frequencies[16*i +: 16],
                                     max_freq);
            end
        end
    end

    // Step selection: single selects beat binary bits, lowest wins.
    logic [2:0] step_sel;
    always_comb begin
        step_sel = {func_active[dis_pkg::FN_SSBIT0 + 2],
                    func_active[dis_pkg::FN_SSBIT0 + 1],
                    func_active[dis_pkg::FN_SSBIT0]};
        for (int s = 6; s >= 0; s--) begin
            if (func_active[dis_pkg::FN_STEP1 + s]) step_sel = 3'(s + 1);
        end
    end

    // Skip band logic: raise into the top of any band hit.
    logic [15:0] pre_freq;
    logic [15:0] skip_freq;
    logic skip_en;
    assign pre_freq = (step_sel == 3'h0) ? base_freq : preset[step_sel - 3'h1];
    assign skip_en = (skip_band_settings != '0);
    always_comb begin
        logic [16:0] lo;
        logic [16:0] hi;
        lo = '0;
        hi = '0;
        skip_freq = pre_freq;
        // Two passes let overlapping or nested bands merge.
        for (int p = 0; p < 2; p++) begin
            for (int b = 0; b < 3; b++) begin
                lo = {1'b0, skip_band_settings[16*b +: 16]}
                   - {1'b0, skip_bandwidth};
                hi = {1'b0, skip_band_settings[16*b +: 16]}
                   + {1'b0, skip_bandwidth};
                if (skip_band_settings[16*b +: 16] != '0 &&
                    {1'b0, skip_freq} > lo && {1'b0, skip_freq} < hi) begin
                    skip_freq = (hi[16]) ? 16'hffff : hi[15:0];
                end
            end
        end
    end

    // Output frequency, zero for inhibited keypad reverse.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            target_freq <= '0;
            zero_speed <= 1'b0;
        end else begin
            zero_speed <= reverse_inhibit_setting & keypad_reverse;
            if (reverse_inhibit_setting & keypad_reverse) begin
                target_freq <= '0;
            end else begin
                target_freq <= clamp_f(skip_en ? skip_freq : pre_freq,
                                       max_freq);
            end
        end
    end

    // PID amplitude from step one under PID combination.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pid_amplitude <= '0;
        end else if (freq_combination_select >= dis_pkg::COMB_PID_LO &&
                     freq_combination_select <= dis_pkg::COMB_PID_HI &&
                     primary_freq_source == dis_pkg::SRC_PID) begin
            pid_amplitude <= preset[0];
        end else begin
            pid_amplitude <= '0;
        end
    end

    // Ramp set selection: single selects first, then binary bits.
    logic [1:0] ramp_sel;
    always_comb begin
        ramp_sel = {func_active[dis_pkg::FN_RTBIT1],
                    func_active[dis_pkg::FN_RTBIT0]};
        for (int s = 3; s >= 0; s--) begin
            if (func_active[dis_pkg::FN_RAMP1 + s]) ramp_sel = 2'(s);
        end
    end

    // Limit a ramp time into its legal span.
    function automatic logic [15:0] clamp_t(input logic [15:0] t);
        clamp_t = (t < dis_pkg::RAMP_MIN) ? dis_pkg::RAMP_MIN :
                  (t > dis_pkg::RAMP_MAX) ? dis_pkg::RAMP_MAX : t;
    endfunction : clamp_t

    // Ramp time outputs.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            accel_time <= dis_pkg::RAMP_MIN;
            decel_time <= dis_pkg::RAMP_MIN;
        end else if (seq_or_inch_active) begin
            accel_time <= mode_ramp_times[15:0];
            decel_time <= mode_ramp_times[31:16];
        end else if (ramp_sel == 2'h0) begin
            accel_time <= ramp_time_set_1[15:0];
            decel_time <= ramp_time_set_1[31:16];
        end else begin
            accel_time <= clamp_t(ramp_time_sets_2_to_4[32*(ramp_sel-1) +: 16]);
            decel_time <= clamp_t(
                ramp_time_sets_2_to_4[32*(ramp_sel-1)+16 +: 16]);
        end
    end

    // Fan control with temperature hysteresis when stopped.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fan_on <= 1'b0;
        end else if (fan_policy_setting) begin
            fan_on <= 1'b1;
        end else if (running) begin
            fan_on <= 1'b1;
        end else if (stage_temp > dis_pkg::FAN_ON_TEMP) begin
            fan_on <= 1'b1;
        end else if (stage_temp < dis_pkg::FAN_OFF_TEMP) begin
            fan_on <= 1'b0;
        end
    end

    // Phase order swap.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_swap <= 1'b0;
        end else begin
            phase_swap <= phase_order_setting;
        end
    end

    // Checks.
    a_reset_edge_only: assert property (
        @(posedge clk) disable iff (!nrst)
        fault_clear |-> $past(faulted) && $past(reset_edge))
        else $error("fault clear without reset edge");
    a_reverse_block: assert property (
        @(posedge clk) disable iff (!nrst)
        $past(reverse_inhibit_setting) |-> !start_bwd)
        else $error("reverse start while inhibited");
    a_fan_always: assert property (
        @(posedge clk) disable iff (!nrst)
        $past(fan_policy_setting) |-> fan_on)
        else $error("fan off in always-on mode");
    a_fan_hot: assert property (
        @(posedge clk) disable iff (!nrst)
        $past(stage_temp) > dis_pkg::FAN_ON_TEMP |-> fan_on)
        else $error("fan off while hot");
    a_zero_rev: assert property (
        @(posedge clk) disable iff (!nrst)
        zero_speed |-> target_freq == '0)
        else $error("reverse inhibit not zero speed");
    a_phase_follow: assert property (
        @(posedge clk) disable iff (!nrst)
        ##1 phase_swap == $past(phase_order_setting))
        else $error("phase swap not following setting");
    a_ramp_mode: assert property (
        @(posedge clk) disable iff (!nrst)
        $past(seq_or_inch_active) |->
            accel_time == $past(mode_ramp_times[15:0]))
        else $error("mode ramp not used");
    a_freq_limit: assert property (
        @(posedge clk) disable iff (!nrst)
        ##1 target_freq <= $past(max_freq))
        else $error("frequency over maximum");
endmodule : dis_input_setpoint

// *** sim/dis_field_switches.sv ***
// Field switch model for the eight drive input terminals.
// Assumes the bench says which contacts are closed to common.
`timescale 1ns/1ps
module dis_field_switches (
    // Contact states from the bench.
    input wire logic [7:0] closed,
    // Terminal levels seen by the drive.
    output logic [7:0] pins
);
    // A contact is a plain short to common, so a closed contact reads high.
    // It changes at any time, which is why the drive must synchronise it.
    assign pins = closed;
endmodule : dis_field_switches

// *** sim/test_dis_input_setpoint.sv ***
// Self-checking bench for the drive input and setpoint block.
// Assumes the field switch model drives the terminals.
`timescale 1ns/1ps
module test_dis_input_setpoint;
    // An expected result: which output, and its value.
    typedef struct {int kind; logic [15:0] val;} dis_note_type;
    dis_note_type notes[$];
    string names[12] = '{"accel_time", "decel_time", "target_freq",
        "pid_amplitude", "term_asserted", "fan_on", "phase_swap",
        "zero_speed", "start_bwd", "stop_request", "clear_pulses",
        "stop_pulses"};
    int errors = 0;
    int check_count = 0;
    int pulses = 0;
    int stops = 0; // Stop pulses raised while the drive runs.
    logic stop_prev = 1'b0;
    // Stimulus, all given a value at time zero.
    logic clk = 0, nrst = 0, pol = 0, seq = 0, fanp = 0, phase = 0;
    logic rinh = 0, kprev = 0, running = 0, faulted = 0;
    logic [7:0] closed = 8'h00, temp = 8'h14, pins;
    logic [47:0] codes = 48'h0000_0000_0000, skips = 48'h0000_0000_0000;
    logic [15:0] bw = 16'h0000, seed = 16'h5191;
    logic [2:0] comb = 3'h0;
    logic [3:0] src = 4'h0;
    logic [31:0] ramp1 = 32'h0001_0001, mode_rt = 32'h0001_0001;
    logic [95:0] ramps = {6{16'h0001}};
    // Design outputs.
    logic [15:0] target, pid, acc, dec;
    logic [7:0] tasrt;
    logic fan, swp, zs, sfwd, sbwd, fclr, stopr;

    dis_field_switches sw (.closed(closed), .pins(pins));
    dis_input_setpoint #(.N_TERM(8)) dut (.clk, .nrst,
        .multi_function_input_pins(pins), .terminal_polarity_setting(pol),
        .terminal_function_codes(codes), .small_model(1'b0),
        .max_freq(16'h1770), .base_freq(16'h1388),
        .skip_band_settings(skips), .skip_bandwidth(bw),
        .preset_step_frequencies({7{16'h0000}}), .preset_load(1'b0),
        .freq_combination_select(comb), .primary_freq_source(src),
        .ramp_time_set_1(ramp1), .ramp_time_sets_2_to_4(ramps),
        .mode_ramp_times(mode_rt), .seq_or_inch_active(seq),
        .fan_policy_setting(fanp), .stage_temp(temp),
        .phase_order_setting(phase), .reverse_inhibit_setting(rinh),
        .keypad_reverse(kprev), .running, .faulted, .target_freq(target),
        .pid_amplitude(pid), .accel_time(acc), .decel_time(dec),
        .fan_on(fan), .phase_swap(swp), .zero_speed(zs),
        .term_asserted(tasrt), .func_active(), .start_fwd(sfwd),
        .start_bwd(sbwd), .fault_clear(fclr), .stop_request(stopr));

    // Free-running 50 MHz clock.
    initial begin
        forever #10 clk = ~clk;
    end

    // The clear output is a one-cycle pulse, so pulses are counted here.
    always @(posedge clk) begin
        if (fclr === 1'b1) pulses++;
    end

    // A stop from the reset edge lasts one cycle, so rises are counted.
    always @(posedge clk) begin
        if (stopr === 1'b1 && stop_prev !== 1'b1 && running === 1'b1)
            stops++;
        stop_prev = stopr;
    end

    // Pseudo-random step for ramp times.
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Codes for terminals one to three; the rest stay unused.
    function automatic logic [47:0] cd3(logic [5:0] a, b, c);
        return {30'h0000_0000, c, b, a};
    endfunction : cd3

    // Current value of one watched output, widened to a word.
    function automatic logic [15:0] obs(int k);
        case (k)
            0: return acc;
            1: return dec;
            2: return target;
            3: return pid;
            4: return {8'h00, tasrt};
            5: return {15'h0000, fan};
            6: return {15'h0000, swp};
            7: return {15'h0000, zs};
            8: return {15'h0000, sbwd};
            9: return {15'h0000, stopr};
            11: return stops[15:0];
            default: return pulses[15:0];
        endcase
    endfunction : obs

    task automatic check_word(string n, logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : check_word

    task automatic check_bit(string n, logic e, logic g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %b, seen %b", n, e, g);
        end
    endtask : check_bit

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // Note an expectation and hold the stimulus until it has been judged.
    task automatic want(int k, logic [15:0] v);
        int t;
        t = 0;
        notes.push_back('{k, v});
        while (notes.size() > 0 && t < 100) begin
            @(posedge clk);
            t++;
        end
        if (t >= 100) begin
            errors++;
            print_verdict();
        end
    endtask : want

    // Watcher: outputs answer within five edges, so six are let pass first;
    // a short grace poll follows so a slow answer is still judged.
    initial begin : watch
        int t;
        forever begin
            @(negedge clk);
            if (notes.size() > 0) begin
                repeat (6) @(negedge clk);
                t = 0;
                while (obs(notes[0].kind) !== notes[0].val && t < 6) begin
                    @(negedge clk);
                    t++;
                end
                if (notes[0].kind < 5 || notes[0].kind >= 10)
                    check_word(names[notes[0].kind], notes[0].val,
                        obs(notes[0].kind));
                else
                    check_bit(names[notes[0].kind], notes[0].val[0],
                        obs(notes[0].kind) === 16'h0001);
                void'(notes.pop_front());
            end
        end
    end

    initial begin : main
        logic [15:0] v [8];
        int b;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        // Polarity, unused terminals and one function on two terminals.
        @(posedge clk) codes <= cd3(dis_pkg::FN_COAST, dis_pkg::FN_COAST,
            dis_pkg::FN_NONE);
        @(posedge clk) closed <= 8'h04;
        want(4, 16'h0004);
        want(9, 16'h0000);
        @(posedge clk) closed <= 8'h02;
        want(9, 16'h0001);
        @(posedge clk) begin
            pol <= 1'b1;
            closed <= 8'h03;
        end
        want(4, 16'h00fc);
        want(9, 16'h0000);
        @(posedge clk) begin
            pol <= 1'b0;
            closed <= 8'h00;
        end
        $display("test polarity done");
        // Let the contacts settle first, so recoding makes no false edge.
        repeat (5) @(posedge clk);
        // Reset terminal acts on its rising edge only.
        @(posedge clk) begin
            codes <= cd3(dis_pkg::FN_RESET, dis_pkg::FN_NONE,
                dis_pkg::FN_NONE);
            faulted <= 1'b1;
        end
        want(10, 16'h0000);
        @(posedge clk) closed <= 8'h01;
        want(10, 16'h0001);
        want(10, 16'h0001);
        @(posedge clk) closed <= 8'h00;
        want(10, 16'h0001);
        @(posedge clk) begin
            faulted <= 1'b0;
            running <= 1'b1;
            closed <= 8'h01;
        end
        want(11, 16'h0001);
        @(posedge clk) closed <= 8'h00;
        $display("test reset terminal done");
        // Ramp sets chosen by the two binary bits, then mode override.
        for (b = 0; b < 8; b++) begin
            seed = lfsr(seed);
            v[b] = 16'(int'(seed) % 36000 + 1);
        end
        @(posedge clk) begin
            ramp1 <= {v[1], v[0]};
            ramps <= {v[7], v[6], v[5], v[4], v[3], v[2]};
            mode_rt <= {16'h0007, 16'h0009};
            codes <= cd3(dis_pkg::FN_RTBIT0, dis_pkg::FN_RTBIT1,
                dis_pkg::FN_NONE);
        end
        for (b = 0; b < 4; b++) begin
            @(posedge clk) closed <= 8'(b);
            want(0, v[2 * b]);
            want(1, v[2 * b + 1]);
        end
        @(posedge clk) seq <= 1'b1;
        want(0, 16'h0009);
        @(posedge clk) seq <= 1'b0;
        $display("test ramp select done");
        // Single step selects, skip bands and PID amplitude.
        for (b = 0; b < 7; b++) begin
            @(posedge clk) begin
                codes <= cd3(6'(dis_pkg::FN_STEP1 + b), dis_pkg::FN_NONE,
                    dis_pkg::FN_NONE);
                closed <= 8'h01;
            end
            want(2, dis_pkg::STEP_DEF[b]);
        end
        @(posedge clk) begin
            codes <= cd3(dis_pkg::FN_STEP1, dis_pkg::FN_NONE,
                dis_pkg::FN_NONE);
            skips <= {32'h0000_0000, 16'h01f4};
            bw <= 16'h0064;
        end
        want(2, 16'h0258);
        @(posedge clk) skips <= {16'h0000, 16'h028a, 16'h01f4};
        want(2, 16'h02ee);
        @(posedge clk) begin
            comb <= dis_pkg::COMB_PID_LO;
            src <= dis_pkg::SRC_PID;
        end
        want(3, dis_pkg::STEP_DEF[0]);
        $display("test setpoint done");
        // Fan policy, hysteresis after stop, and the always-on mode.
        want(5, 16'h0001);
        @(posedge clk) begin
            running <= 1'b0;
            temp <= 8'h46;
        end
        want(5, 16'h0001);
        @(posedge clk) temp <= 8'h37;
        want(5, 16'h0001);
        @(posedge clk) temp <= 8'h2d;
        want(5, 16'h0000);
        @(posedge clk) temp <= 8'h37;
        want(5, 16'h0000);
        @(posedge clk) fanp <= 1'b1;
        want(5, 16'h0001);
        $display("test fan done");
        // Phase order, keypad reverse and reverse run terminal.
        @(posedge clk) begin
            phase <= 1'b1;
            rinh <= 1'b1;
            kprev <= 1'b1;
            codes <= cd3(dis_pkg::FN_RUN_BWD, dis_pkg::FN_NONE,
                dis_pkg::FN_NONE);
        end
        want(6, 16'h0001);
        want(7, 16'h0001);
        want(8, 16'h0000);
        @(posedge clk) begin
            phase <= 1'b0;
            rinh <= 1'b0;
            kprev <= 1'b0;
        end
        want(6, 16'h0000);
        want(7, 16'h0000);
        want(8, 16'h0001);
        $display("test direction done");
        print_verdict();
    end
endmodule : test_dis_input_setpoint
